// file: hw/ddrcm_cfg.svh
// constants for the command decoder, mode register and write data path
// Functional notes
// - chip select high masks the command
// - row strobe low selects activate or precharge
// - column strobe low selects read or write
// - commands need clock enable high twice; burst stop is decoded with it high on the previous edge only
// - activate takes bank and row
// - column from bits zero-nine, bit ten autoprecharge
// - burst length four or eight
// - sequential or interleaved ordering
// - read latency field bits six to four
// - write recovery field for auto precharge
// - bit twelve picks active power-down variant
// - mode write with all strobes low
// - masked write data is discarded
`ifndef DDRCM_CFG_SVH
`define DDRCM_CFG_SVH
`define DDRCM_ROW_W 14
`define DDRCM_COL_MSB 9
`define DDRCM_AP_BIT 10
`define DDRCM_BL_LSB 0
`define DDRCM_BL_MSB 2
`define DDRCM_BT_BIT 3
`define DDRCM_CL_LSB 4
`define DDRCM_CL_MSB 6
`define DDRCM_TM_BIT 7
`define DDRCM_DLLR_BIT 8
`define DDRCM_WR_LSB 9
`define DDRCM_WR_MSB 11
`define DDRCM_PD_BIT 12
`define DDRCM_BL4_CODE 3'h2
`define DDRCM_BL8_CODE 3'h3
`define DDRCM_BL4_MASK 3'h3
`define DDRCM_BL8_MASK 3'h7
`define DDRCM_BL4_BEATS 4'h4
`define DDRCM_BL8_BEATS 4'h8
`define DDRCM_MR_BANK 2'h0
`define DDRCM_ENC_ACT 3'h3
`define DDRCM_ENC_PRE 3'h2
`define DDRCM_ENC_RD 3'h5
`define DDRCM_ENC_WR 3'h4
`define DDRCM_ENC_MRS 3'h0
`define DDRCM_ENC_REF 3'h1
`define DDRCM_ENC_NOP 3'h7
`define DDRCM_ENC_BST 3'h6
`define DDRCM_FIFO_DEPTH 32
`define DDRCM_DQ_W 8
`endif

// file: hw/ddrcm_pkg.sv
// types shared by the command decoder and its write data buffer
package ddrcm_pkg;
  typedef enum logic [3:0] {
    DDRCM_NONE = 4'h0, DDRCM_ACT = 4'h1, DDRCM_PRE = 4'h2,
    DDRCM_READ = 4'h3, DDRCM_WRITE = 4'h4, DDRCM_MRS = 4'h5,
    DDRCM_REF = 4'h6, DDRCM_SREF = 4'h7, DDRCM_PDN = 4'h8,
    DDRCM_BST = 4'h9
  } ddrcm_cmd_t;
  typedef enum logic [1:0] {
    DDRCM_ST_IDLE = 2'h0, DDRCM_ST_PWRDN = 2'h1, DDRCM_ST_SELFREF = 2'h3
  } ddrcm_pstate_t;
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_address;
    logic [13:0] addr;
    logic data_mask;
    logic [7:0] dq;
    logic dq_valid;
    logic termination_control;
  } ddrcm_pins_t;
  typedef struct packed {
    ddrcm_cmd_t cmd;
    logic [1:0] bank;
    logic [13:0] addr;
    logic auto_pre;
  } ddrcm_cmd_out_t;
  typedef struct packed {
    logic [9:0] col;
    logic [7:0] data;
  } ddrcm_wbeat_t;
endpackage

// file: hw/ddrcm_fifo.sv
// write data buffer with registered read data
`timescale 1ns/100ps
`default_nettype none
module ddrcm_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic push;
  logic pop;

  // handshake terms
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign pop = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  // storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // output register stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= mem[rptr_reg];
    end else if (out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: hw/ddrcm_core.sv
// command decoder, bank tracking, mode register and write data capture
`timescale 1ns/100ps
`default_nettype none
`include "ddrcm_cfg.svh"
module ddrcm_core #(
  parameter int FIFO_DEPTH = `DDRCM_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // command and data pins
  input wire ddrcm_pkg::ddrcm_pins_t pins,
  // decoded command
  output logic cmd_valid,
  output ddrcm_pkg::ddrcm_cmd_out_t cmd_out,
  // device state
  output logic [3:0] bank_open,
  output logic [13:0] mode_reg,
  output logic mode_valid,
  output logic [2:0] cas_latency,
  output logic [2:0] write_recovery,
  output logic burst_len8,
  output logic burst_interleave,
  output ddrcm_pkg::ddrcm_pstate_t power_state,
  output logic pd_slow_exit,
  output logic term_on,
  output logic ext_write,
  output logic [1:0] ext_select,
  // write data stream
  output logic wdata_ready,
  output logic wbeat_valid,
  input wire logic wbeat_ready,
  output ddrcm_pkg::ddrcm_wbeat_t wbeat
);
  ddrcm_pkg::ddrcm_pins_t sync1_reg;
  ddrcm_pkg::ddrcm_pins_t p;
  logic cke_prev_reg;
  ddrcm_pkg::ddrcm_cmd_t dec;
  ddrcm_pkg::ddrcm_cmd_out_t cmd_reg;
  logic cmd_valid_reg;
  logic [3:0] bank_open_reg;
  logic [13:0] mode_reg_reg;
  logic mode_valid_reg;
  ddrcm_pkg::ddrcm_pstate_t pstate_reg;
  logic ext_write_reg;
  logic [1:0] ext_select_reg;
  logic [3:0] burst_left_reg;
  logic [2:0] beat_idx_reg;
  logic [9:0] start_col_reg;
  logic [1:0] wr_bank_reg;
  logic wr_ap_reg;
  logic [3:0] rec_cnt_reg;
  logic rec_act_reg;
  logic [2:0] mask;
  logic [2:0] low;
  logic beat_take;
  logic push;
  logic ord_ok;

  // two-stage capture of every pin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1_reg <= '0;
      p <= '0;
    end else begin
      sync1_reg <= pins;
      p <= sync1_reg;
    end
  end

  // clock enable of the previous edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= p.cke;
    end
  end

  // command decode from the strobe pattern
  assign ord_ok = cke_prev_reg && p.cke;
  always_comb begin
    dec = ddrcm_pkg::DDRCM_NONE;
    if (!p.cs_n && cke_prev_reg) begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        `DDRCM_ENC_ACT: if (ord_ok) dec = ddrcm_pkg::DDRCM_ACT;
        `DDRCM_ENC_PRE: if (ord_ok) dec = ddrcm_pkg::DDRCM_PRE;
        `DDRCM_ENC_RD: if (ord_ok) dec = ddrcm_pkg::DDRCM_READ;
        `DDRCM_ENC_WR: if (ord_ok) dec = ddrcm_pkg::DDRCM_WRITE;
        `DDRCM_ENC_MRS: if (ord_ok) dec = ddrcm_pkg::DDRCM_MRS;
        `DDRCM_ENC_REF: begin
          dec = p.cke ? ddrcm_pkg::DDRCM_REF : ddrcm_pkg::DDRCM_SREF;
        end
        `DDRCM_ENC_NOP: if (!p.cke) dec = ddrcm_pkg::DDRCM_PDN;
        `DDRCM_ENC_BST: dec = ddrcm_pkg::DDRCM_BST;
      endcase
    end
  end

  // registered command report
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_valid_reg <= 1'b0;
      cmd_reg <= '0;
    end else begin
      cmd_valid_reg <= (dec != ddrcm_pkg::DDRCM_NONE);
      cmd_reg.cmd <= dec;
      cmd_reg.bank <= p.bank_address;
      cmd_reg.addr <= p.addr;
      cmd_reg.auto_pre <= p.addr[`DDRCM_AP_BIT];
    end
  end

  // open-bank tracking
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bank_open_reg <= '0;
    end else begin
      if (rec_act_reg && rec_cnt_reg == 4'h0) begin
        bank_open_reg[wr_bank_reg] <= 1'b0;
      end
      unique case (dec)
        ddrcm_pkg::DDRCM_ACT: bank_open_reg[p.bank_address] <= 1'b1;
        ddrcm_pkg::DDRCM_PRE: begin
          if (p.addr[`DDRCM_AP_BIT]) begin
            bank_open_reg <= '0;
          end else begin
            bank_open_reg[p.bank_address] <= 1'b0;
          end
        end
        ddrcm_pkg::DDRCM_READ: begin
          if (p.addr[`DDRCM_AP_BIT]) begin
            bank_open_reg[p.bank_address] <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // mode register and extended register strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_reg_reg <= '0;
      mode_valid_reg <= 1'b0;
      ext_write_reg <= 1'b0;
      ext_select_reg <= '0;
    end else begin
      ext_write_reg <= 1'b0;
      if (dec == ddrcm_pkg::DDRCM_MRS) begin
        if (p.bank_address == `DDRCM_MR_BANK) begin
          mode_reg_reg <= p.addr;
          mode_valid_reg <= 1'b1;
        end else begin
          ext_write_reg <= 1'b1;
          ext_select_reg <= p.bank_address;
        end
      end
    end
  end

  // power state: self-refresh, power-down and their exit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pstate_reg <= ddrcm_pkg::DDRCM_ST_IDLE;
    end else begin
      unique case (pstate_reg)
        ddrcm_pkg::DDRCM_ST_IDLE: begin
          if (dec == ddrcm_pkg::DDRCM_SREF) begin
            pstate_reg <= ddrcm_pkg::DDRCM_ST_SELFREF;
          end else if (dec == ddrcm_pkg::DDRCM_PDN) begin
            pstate_reg <= ddrcm_pkg::DDRCM_ST_PWRDN;
          end
        end
        ddrcm_pkg::DDRCM_ST_PWRDN, ddrcm_pkg::DDRCM_ST_SELFREF: begin
          if (!cke_prev_reg && p.cke) begin
            pstate_reg <= ddrcm_pkg::DDRCM_ST_IDLE;
          end
        end
        default: pstate_reg <= ddrcm_pkg::DDRCM_ST_IDLE;
      endcase
    end
  end

  // write burst window and beat ordering
  assign mask = burst_len8 ? `DDRCM_BL8_MASK : `DDRCM_BL4_MASK;
  always_comb begin
    if (burst_interleave) begin
      low = start_col_reg[2:0] ^ beat_idx_reg;
    end else begin
      low = start_col_reg[2:0] + beat_idx_reg;
    end
  end
  assign beat_take = (burst_left_reg != 4'h0) && p.dq_valid;
  assign push = beat_take && !p.data_mask && (bank_open_reg != '0);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      burst_left_reg <= '0;
      beat_idx_reg <= '0;
      start_col_reg <= '0;
      wr_bank_reg <= '0;
      wr_ap_reg <= 1'b0;
    end else if (dec == ddrcm_pkg::DDRCM_WRITE) begin
      burst_left_reg <= burst_len8 ? `DDRCM_BL8_BEATS : `DDRCM_BL4_BEATS;
      beat_idx_reg <= '0;
      start_col_reg <= p.addr[`DDRCM_COL_MSB:0];
      wr_bank_reg <= p.bank_address;
      wr_ap_reg <= p.addr[`DDRCM_AP_BIT];
    end else if (beat_take) begin
      burst_left_reg <= burst_left_reg - 4'h1;
      beat_idx_reg <= beat_idx_reg + 3'h1;
    end
  end

  // write recovery before auto precharge closes the bank
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rec_cnt_reg <= '0;
      rec_act_reg <= 1'b0;
    end else if (beat_take && burst_left_reg == 4'h1 && wr_ap_reg) begin
      rec_cnt_reg <= {1'b0, write_recovery};
      rec_act_reg <= 1'b1;
    end else if (rec_act_reg) begin
      if (rec_cnt_reg == 4'h0) begin
        rec_act_reg <= 1'b0;
      end else begin
        rec_cnt_reg <= rec_cnt_reg - 4'h1;
      end
    end
  end

  // write data buffer
  ddrcm_fifo #(
    .WIDTH($bits(ddrcm_pkg::ddrcm_wbeat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(push),
    .in_ready(wdata_ready),
    .in_data({start_col_reg[`DDRCM_COL_MSB:3],
              (start_col_reg[2:0] & ~mask) | (low & mask), p.dq}),
    .out_valid(wbeat_valid),
    .out_ready(wbeat_ready),
    .out_data(wbeat)
  );

  // field outputs of the mode register
  assign burst_len8 = (mode_reg_reg[`DDRCM_BL_MSB:`DDRCM_BL_LSB]
                       == `DDRCM_BL8_CODE);
  assign burst_interleave = mode_reg_reg[`DDRCM_BT_BIT];
  assign cas_latency = mode_reg_reg[`DDRCM_CL_MSB:`DDRCM_CL_LSB];
  assign write_recovery = mode_reg_reg[`DDRCM_WR_MSB:`DDRCM_WR_LSB];
  assign pd_slow_exit = mode_reg_reg[`DDRCM_PD_BIT] && (bank_open_reg != '0)
                        && (pstate_reg == ddrcm_pkg::DDRCM_ST_PWRDN);

  // remaining outputs
  assign cmd_valid = cmd_valid_reg;
  assign cmd_out = cmd_reg;
  assign bank_open = bank_open_reg;
  assign mode_reg = mode_reg_reg;
  assign mode_valid = mode_valid_reg;
  assign power_state = pstate_reg;
  assign term_on = p.termination_control
                   && (pstate_reg != ddrcm_pkg::DDRCM_ST_SELFREF);
  assign ext_write = ext_write_reg;
  assign ext_select = ext_select_reg;

  // checks, all on the system clock and masked during reset
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  chk_desel_masked: assert property (p.cs_n |=> !cmd_valid)
    else $error("command taken while deselected");
  chk_act_opens: assert property (
    cmd_valid && cmd_out.cmd == ddrcm_pkg::DDRCM_ACT
    |-> bank_open[cmd_out.bank])
    else $error("activate left bank shut");
  chk_read_decode: assert property (
    cmd_valid && cmd_out.cmd == ddrcm_pkg::DDRCM_READ
    |-> $past(p.ras_n && !p.cas_n && p.we_n))
    else $error("bad read decode");
  chk_pre_all: assert property (
    cmd_valid && cmd_out.cmd == ddrcm_pkg::DDRCM_PRE && cmd_out.auto_pre
    |-> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  chk_sref_entry: assert property (
    cmd_valid && cmd_out.cmd == ddrcm_pkg::DDRCM_SREF
    |-> power_state == ddrcm_pkg::DDRCM_ST_SELFREF)
    else $error("self-refresh not entered");
  chk_cke_gate: assert property (
    cmd_valid && cmd_out.cmd inside {ddrcm_pkg::DDRCM_ACT,
    ddrcm_pkg::DDRCM_WRITE, ddrcm_pkg::DDRCM_MRS}
    |-> $past(cke_prev_reg && p.cke))
    else $error("command with clock enable low");
  chk_mode_capture: assert property (
    dec == ddrcm_pkg::DDRCM_MRS && p.bank_address == `DDRCM_MR_BANK
    |=> mode_reg == $past(p.addr) && mode_valid)
    else $error("mode write lost");
  chk_burst_len: assert property (
    dec == ddrcm_pkg::DDRCM_WRITE |=> burst_left_reg == ($past(burst_len8)
    ? `DDRCM_BL8_BEATS : `DDRCM_BL4_BEATS))
    else $error("bad burst length");
  // a masked beat must never grow the buffer fill
  chk_mask_drop: assert property (
    beat_take && p.data_mask
    |=> u_fifo.count_reg <= $past(u_fifo.count_reg))
    else $error("masked beat stored");
  chk_pd_variant: assert property (
    pd_slow_exit |-> power_state == ddrcm_pkg::DDRCM_ST_PWRDN
    && bank_open != 4'h0)
    else $error("slow exit outside active power-down");
  cov_activate: cover property (@(posedge clk_sys)
    cmd_valid && cmd_out.cmd == ddrcm_pkg::DDRCM_ACT);
  cov_write_push: cover property (@(posedge clk_sys) push ##1 push);
  cov_self_refresh: cover property (@(posedge clk_sys)
    power_state == ddrcm_pkg::DDRCM_ST_SELFREF);
  cov_mode_write: cover property (@(posedge clk_sys)
    dec == ddrcm_pkg::DDRCM_MRS);
endmodule
`default_nettype wire

// file: hw/ddrcm_unused_guard.sv
// no further logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: tb/ddrcm_ctrl_model.sv
// controller-side model driving the command, address and write data pins
`timescale 1ns/100ps
`default_nettype none
module ddrcm_ctrl_model #(
  parameter int PWRUP_CYC = 20000,
  parameter int MRD_CYC = 2
) (
  // clock
  input wire logic clk_sys,
  // pins toward the device
  output var ddrcm_pkg::ddrcm_pins_t pins
);
  // power-up: clock enable and termination low, device deselected
  initial begin
    pins = '{cs_n: 1'b1, default: '0};
  end
  // one command cycle, launched after a falling edge
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba,
      input logic [13:0] a, input logic ke);
    @(negedge clk_sys);
    pins.cke = ke;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
    pins.bank_address = ba;
    pins.addr = a;
  endtask
  // deselect; released lines change every cycle so stale values never pass
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      pins.cs_n = 1'b1;
      pins.addr = ~pins.addr;
      pins.bank_address = ~pins.bank_address;
      pins.dq_valid = 1'b0;
      pins.dq = ~pins.dq;
    end
  endtask
  // write data beats, one per cycle, mask bit i for beat i
  task automatic beats(input int n, input logic [7:0] d0,
      input logic [7:0] m);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      pins.cs_n = 1'b1;
      pins.dq_valid = 1'b1;
      pins.dq = d0 + 8'(i);
      pins.data_mask = m[i];
    end
    idle(1);
  endtask
  // termination input level
  task automatic term(input logic v);
    @(negedge clk_sys);
    pins.termination_control = v;
  endtask
  // mode or extended register write, then the mode write cycle time
  task automatic mwr(input logic [1:0] ba, input logic [13:0] a);
    cmd(4'h0, ba, a, 1'b1);
    idle(MRD_CYC);
  endtask
  // power-up and initialization sequence
  task automatic init(input logic [13:0] mode);
    idle(PWRUP_CYC);
    cmd(4'h7, 2'h0, 14'h0, 1'b1);
    idle(40);
    cmd(4'h2, 2'h0, 14'h0400, 1'b1);
    mwr(2'h2, 14'h0);
    mwr(2'h3, 14'h0);
    mwr(2'h1, 14'h0);
    mwr(2'h0, mode | 14'h0100);
    cmd(4'h2, 2'h0, 14'h0400, 1'b1);
    cmd(4'h1, 2'h0, 14'h0, 1'b1);
    cmd(4'h1, 2'h0, 14'h0, 1'b1);
    mwr(2'h0, mode & 14'h1e7f);
    idle(200);
    mwr(2'h1, 14'h0380);
    mwr(2'h1, 14'h0);
  endtask
endmodule
`default_nettype wire

// file: tb/test_ddrcm_core.sv
// self-checking bench for the command decoder and write data path
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module test_ddrcm_core;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic wbeat_ready = 1'b1;
  ddrcm_pkg::ddrcm_pins_t pins;
  logic cmd_valid, mode_valid, burst_len8, burst_interleave;
  ddrcm_pkg::ddrcm_cmd_out_t cmd_out;
  logic [3:0] bank_open;
  logic [13:0] mode_reg;
  logic [2:0] cas_latency, write_recovery;
  ddrcm_pkg::ddrcm_pstate_t power_state;
  logic pd_slow_exit, term_on, ext_write, wdata_ready, wbeat_valid;
  logic [1:0] ext_select;
  ddrcm_pkg::ddrcm_wbeat_t wbeat;
  int num_errors = 0;
  int checks = 0;
  logic saw_full = 1'b0;
  ddrcm_pkg::ddrcm_wbeat_t got_q[$];

  ddrcm_ctrl_model #(.PWRUP_CYC(20), .MRD_CYC(2)) ctrl_i (
    .clk_sys(clk_sys), .pins(pins));
  ddrcm_core #(.FIFO_DEPTH(32)) ddrcm_core_i (
    .clk_sys(clk_sys), .srst(srst), .pins(pins), .cmd_valid(cmd_valid),
    .cmd_out(cmd_out), .bank_open(bank_open), .mode_reg(mode_reg),
    .mode_valid(mode_valid), .cas_latency(cas_latency),
    .write_recovery(write_recovery), .burst_len8(burst_len8),
    .burst_interleave(burst_interleave), .power_state(power_state),
    .pd_slow_exit(pd_slow_exit), .term_on(term_on), .ext_write(ext_write),
    .ext_select(ext_select), .wdata_ready(wdata_ready),
    .wbeat_valid(wbeat_valid), .wbeat_ready(wbeat_ready), .wbeat(wbeat));

  // clock
  always #5 clk_sys = ~clk_sys;
  // collect accepted write beats and note a full buffer
  always @(posedge clk_sys) begin
    if (wbeat_valid === 1'b1 && wbeat_ready) got_q.push_back(wbeat);
    if (wdata_ready === 1'b0) saw_full <= 1'b1;
  end

  // print counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // issue a command and wait a bounded time for the decode pulse
  task automatic run(input logic [3:0] c, input logic [1:0] ba,
      input logic [13:0] a, input logic ke, input logic want);
    logic seen;
    seen = 1'b0;
    ctrl_i.cmd(c, ba, a, ke);
    for (int i = 0; i < 6 && !seen; i++) begin
      ctrl_i.idle(1);
      seen = (cmd_valid === 1'b1);
    end
    `CHECK(seen, want)
    if (want && !seen) print_verdict();
  endtask
  // compare collected beats with the expected burst order and mask
  task automatic chk_burst(input logic [9:0] st, input int bl,
      input logic ilv, input logic [7:0] m, input logic [7:0] d0);
    logic [9:0] msk, col;
    ddrcm_pkg::ddrcm_wbeat_t b;
    ctrl_i.idle(12);
    msk = 10'(bl - 1);
    for (int i = 0; i < bl; i++) begin
      col = ilv ? (st ^ 10'(i)) : ((st & ~msk) | ((st + 10'(i)) & msk));
      if (!m[i]) begin
        b = got_q.size() > 0 ? got_q.pop_front() : '0;
        `CHECK(b, {col, d0 + 8'(i)})
      end
    end
    `CHECK(got_q.size(), 0)
  endtask

  // main sequence
  initial begin
    repeat (2) @(negedge clk_sys);
    `CHECK({bank_open, mode_valid, cmd_valid}, 6'h00)
    `CHECK({wbeat_valid, wdata_ready}, 2'b01)
    `CHECK(mode_reg, 14'h0)
    srst = 1'b0;
    $display("test reset done");
    ctrl_i.init(14'h1632);
    ctrl_i.idle(4);
    `CHECK({mode_valid, mode_reg}, {1'b1, 14'h1632})
    `CHECK({cas_latency, write_recovery}, 6'h1b)
    `CHECK({burst_len8, burst_interleave}, 2'b00)
    run(4'h0, 2'h2, 14'h0, 1'b1, 1'b1);
    `CHECK({ext_write, ext_select, mode_reg}, {3'b110, 14'h1632})
    $display("test init done");
    run(4'hb, 2'h1, 14'h0005, 1'b1, 1'b0);
    run(4'h3, 2'h1, 14'h2abc, 1'b1, 1'b1);
    `CHECK(cmd_out, {ddrcm_pkg::DDRCM_ACT, 2'h1, 14'h2abc, 1'b0})
    run(4'h3, 2'h0, 14'h1555, 1'b1, 1'b1);
    `CHECK(bank_open, 4'h3)
    run(4'h2, 2'h1, 14'h0000, 1'b1, 1'b1);
    `CHECK(bank_open, 4'h1)
    run(4'h2, 2'h1, 14'h0400, 1'b1, 1'b1);
    `CHECK(bank_open, 4'h0)
    $display("test bank done");
    run(4'h3, 2'h0, 14'h0000, 1'b1, 1'b1);
    run(4'h4, 2'h0, 14'h0006, 1'b1, 1'b1);
    `CHECK(cmd_out.cmd, ddrcm_pkg::DDRCM_WRITE)
    ctrl_i.beats(4, 8'ha0, 8'h02);
    chk_burst(10'h006, 4, 1'b0, 8'h02, 8'ha0);
    run(4'h5, 2'h0, 14'h0405, 1'b1, 1'b1);
    `CHECK({cmd_out.cmd, cmd_out.auto_pre, bank_open}, 9'h070)
    ctrl_i.mwr(2'h0, 14'h163b);
    run(4'h3, 2'h3, 14'h0000, 1'b1, 1'b1);
    `CHECK({burst_len8, burst_interleave}, 2'b11)
    ctrl_i.cmd(4'h4, 2'h3, 14'h0403, 1'b1);
    ctrl_i.beats(8, 8'h10, 8'h00);
    chk_burst(10'h003, 8, 1'b1, 8'h00, 8'h10);
    `CHECK(bank_open, 4'h0)
    run(4'h2, 2'h0, 14'h0400, 1'b1, 1'b1);
    $display("test burst done");
    ctrl_i.term(1'b1);
    ctrl_i.cmd(4'h1, 2'h0, 14'h0, 1'b0);
    ctrl_i.idle(4);
    `CHECK({power_state, term_on}, 3'b110)
    run(4'h3, 2'h2, 14'h0000, 1'b0, 1'b0);
    ctrl_i.cmd(4'h7, 2'h0, 14'h0, 1'b1);
    ctrl_i.idle(4);
    `CHECK({power_state, term_on, bank_open}, 7'h10)
    run(4'h1, 2'h0, 14'h0000, 1'b1, 1'b1);
    `CHECK(cmd_out.cmd, ddrcm_pkg::DDRCM_REF)
    run(4'h3, 2'h0, 14'h0000, 1'b1, 1'b1);
    ctrl_i.cmd(4'h7, 2'h0, 14'h0, 1'b0);
    ctrl_i.idle(4);
    `CHECK({power_state, pd_slow_exit}, 3'b011)
    ctrl_i.cmd(4'h7, 2'h0, 14'h0, 1'b1);
    ctrl_i.idle(4);
    `CHECK({power_state, pd_slow_exit}, 3'h0)
    $display("test power done");
    @(negedge clk_sys) wbeat_ready = 1'b0;
    repeat (5) begin
      ctrl_i.cmd(4'h4, 2'h0, 14'h0000, 1'b1);
      ctrl_i.beats(8, 8'h00, 8'h00);
    end
    ctrl_i.idle(4);
    `CHECK({saw_full, wbeat_valid}, 2'b11)
    @(negedge clk_sys) wbeat_ready = 1'b1;
    ctrl_i.idle(45);
    `CHECK({wbeat_valid, wdata_ready, got_q.size() > 31}, 3'b011)
    $display("test buffer done");
    print_verdict();
  end
endmodule
`default_nettype wire
